// ===== core/fpl_config_device.sv
// How it works
// - user mode: request, ack, complete high
// - ack held low through power-on delay
// - load_complete low until data fully received
// - load_complete released after whole image
// - host gives two falling edges after
// - config_clock ignored once configuration completes
// - host drives all 32 bits, or 16 or 8 low bits
// - init_complete low until initialization, if enabled
// - request low drops both lines within 600ns
// - host holds request low at least 2us
// - ack stays low 268 to 1506us
// - ack released within 1506us of request
// - host waits 2us or 1506us before clocking
// - config_clock at most 125 or 100 MHz
// - internal oscillator init takes 175 to 437us
// - user clock: 4 periods then 8576 edges
// - one new word every config_clock cycle
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
module fpl_config_device #(
    parameter int IMAGE_WORDS = fpl_pkg::IMAGE_WORDS,
    parameter int POR_CYC = fpl_pkg::POR_CYC,
    parameter int ACK_MIN_CYC = fpl_pkg::ACK_MIN_CYC,
    parameter int INIT_CYC = fpl_pkg::INIT_CYC,
    parameter int USER_INIT_EDGES = fpl_pkg::USER_INIT_EDGES
) (
    input wire logic sys_clk, // internal oscillator
    input wire logic rst, // sync reset, high
    input wire logic ce, // freezes sys-side state
    input wire logic userInitClock, // optional init clock
    fpl_link_if.dev link, // configuration pins
    output logic userMode, // device in user mode
    output logic optInitPin, // init_complete option loaded
    output logic optUserClk // user clock option loaded
);
    localparam logic [31:0] POR_END = 32'(POR_CYC - 1);
    localparam logic [31:0] ACK_END = 32'(ACK_MIN_CYC - 1);
    localparam logic [31:0] INIT_END = 32'(INIT_CYC - 1);
    localparam logic [31:0] CU_END = 32'(fpl_pkg::CD2CU_CYC);
    localparam logic [31:0] UEDGES = 32'(USER_INIT_EDGES);
    localparam logic [31:0] LAST_WORD = 32'(IMAGE_WORDS - 1);
    localparam logic [1:0] FALLS = 2'(fpl_pkg::FALL_EDGES);

    fpl_pkg::fpl_dev_state_t state;
    fpl_pkg::fpl_dev_state_t next_state;
    logic [31:0] timer;
    logic [31:0] userEdges;
    logic [1:0] reqSync;
    logic [1:0] ackSync;
    logic [1:0] doneSync;
    logic [1:0] fallSync;
    logic [2:0] uclkSync;
    logic reqN;
    logic ackHigh;
    logic doneS;
    logic fallS;
    logic uclkRise;
    logic initDone;
    logic arm;
    logic release_;

    // link-domain state
    logic [1:0] rstL;
    logic [1:0] relL;
    logic linkClr;
    logic [31:0] wordCount;
    logic doneL;
    logic optInitL;
    logic optUclkL;
    logic [1:0] fallCnt;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reqSync <= 2'h3;
            ackSync <= 2'h0;
            doneSync <= 2'h0;
            fallSync <= 2'h0;
            uclkSync <= 3'h0;
        end
        else if (ce)
        begin
            reqSync <= {reqSync[0], link.configRequestN};
            ackSync <= {ackSync[0], link.cfgAckN};
            doneSync <= {doneSync[0], doneL};
            fallSync <= {fallSync[0], fallCnt == FALLS};
            uclkSync <= {uclkSync[1:0], userInitClock};
        end
    end

    assign reqN = reqSync[1];
    assign ackHigh = ackSync[1];
    assign doneS = doneSync[1];
    assign fallS = fallSync[1];
    // user clock must run below half of sys_clk to be counted
    assign uclkRise = uclkSync[1] && !uclkSync[2];

    always_comb
    begin
        initDone = optUserClk ? (timer >= CU_END && userEdges >= UEDGES)
            : (timer >= INIT_END);
    end

    always_comb
    begin
        next_state = state;
        case (state)
            fpl_pkg::DEV_POR:
                if (timer >= POR_END)
                    next_state = fpl_pkg::DEV_ACKLOW;
            fpl_pkg::DEV_ACKLOW:
                if (timer >= ACK_END && reqN)
                    next_state = fpl_pkg::DEV_LOAD;
            fpl_pkg::DEV_LOAD:
                if (doneS)
                    next_state = fpl_pkg::DEV_START;
            fpl_pkg::DEV_START:
                if (fallS)
                    next_state = fpl_pkg::DEV_INIT;
            fpl_pkg::DEV_INIT:
                if (initDone)
                    next_state = fpl_pkg::DEV_USER;
            fpl_pkg::DEV_USER:
                next_state = fpl_pkg::DEV_USER;
            default:
                next_state = fpl_pkg::DEV_POR;
        endcase
        // a reconfiguration request restarts from any later state
        if (!reqN && state != fpl_pkg::DEV_POR
            && state != fpl_pkg::DEV_ACKLOW)
            next_state = fpl_pkg::DEV_ACKLOW;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= fpl_pkg::DEV_POR;
        else if (ce)
            state <= next_state;
    end

    // one timer, restarted on every state change
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            timer <= 32'h0;
        else if (ce)
        begin
            if (next_state != state)
                timer <= 32'h0;
            else if (timer != 32'hffffffff)
                timer <= timer + 32'h1;
        end
    end

    // user clock enabled only after the cd2cu wait
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            userEdges <= 32'h0;
        else if (ce)
        begin
            if (state != fpl_pkg::DEV_INIT)
                userEdges <= 32'h0;
            else if (timer >= CU_END && uclkRise && userEdges != UEDGES)
                userEdges <= userEdges + 32'h1;
        end
    end

    // options are stable in the link domain long before doneS
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            optInitPin <= 1'b0;
            optUserClk <= 1'b0;
        end
        else if (ce)
        begin
            if (state == fpl_pkg::DEV_ACKLOW)
            begin
                optInitPin <= 1'b0;
                optUserClk <= 1'b0;
            end
            else if (state == fpl_pkg::DEV_LOAD && doneS)
            begin
                optInitPin <= optInitL;
                optUserClk <= optUclkL;
            end
        end
    end

    // a flop, so the link side sees a clean level; the host keeps its
    // clock still while arm rises, so it has settled before the first edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            arm <= 1'b0;
        else if (ce)
            arm <= (state == fpl_pkg::DEV_LOAD && ackHigh)
                || state == fpl_pkg::DEV_START;
    end
    assign release_ = state == fpl_pkg::DEV_START;

    assign link.ackDevO = 1'b0;
    assign link.ackDevOeN = !(state == fpl_pkg::DEV_POR
        || state == fpl_pkg::DEV_ACKLOW);
    assign link.loadCompleteO = 1'b0;
    assign link.loadCompleteOeN = !(state == fpl_pkg::DEV_POR
        || state == fpl_pkg::DEV_ACKLOW
        || state == fpl_pkg::DEV_LOAD);
    assign link.initCompleteO = 1'b0;
    assign link.initCompleteOeN = !(optInitPin
        && (state == fpl_pkg::DEV_START
        || state == fpl_pkg::DEV_INIT));
    assign userMode = state == fpl_pkg::DEV_USER;

    // link side; reset and release arrive through two flip-flops
    always_ff @(posedge link.configClock)
    begin
        rstL <= {rstL[0], rst};
        relL <= {relL[0], release_};
    end

    assign linkClr = rstL[1] || !arm;

    // one word per rising edge; counting stops once the image is in
    always_ff @(posedge link.configClock)
    begin
        if (linkClr)
        begin
            wordCount <= 32'h0;
            doneL <= 1'b0;
            optInitL <= 1'b0;
            optUclkL <= 1'b0;
        end
        else if (!doneL)
        begin
            wordCount <= wordCount + 32'h1;
            if (wordCount == 32'h0)
            begin
                optInitL <= link.configWord[fpl_pkg::OPT_INIT_BIT];
                optUclkL <= link.configWord[fpl_pkg::OPT_UCLK_BIT];
            end
            if (wordCount == LAST_WORD)
                doneL <= 1'b1;
        end
    end

    // falling edges counted only while the device is in DEV_START
    always_ff @(negedge link.configClock)
    begin
        if (rstL[1] || !relL[1])
            fallCnt <= 2'h0;
        else if (fallCnt != FALLS)
            fallCnt <= fallCnt + 2'h1;
    end
endmodule // fpl_config_device

// ===== include/fpl_pkg.sv
package fpl_pkg;
    localparam int SYS_MHZ = 125;
    localparam int SYS_PERIOD_NS = 8;
    localparam int T_POR_US = 100;
    localparam int T_ACK_MIN_US = 268;
    localparam int T_CFG_US = 2;
    localparam int T_ST2CK_US = 2;
    localparam int T_CF2CK_US = 1506;
    localparam int T_INIT_MIN_US = 175;
    localparam int T_CCLK_MIN_NS = 8;
    localparam int CD2CU_PERIODS = 4;
    localparam int POR_CYC = T_POR_US * SYS_MHZ;
    localparam int ACK_MIN_CYC = T_ACK_MIN_US * SYS_MHZ;
    localparam int CFG_CYC = T_CFG_US * SYS_MHZ;
    localparam int ST2CK_CYC = T_ST2CK_US * SYS_MHZ;
    localparam int CF2CK_CYC = T_CF2CK_US * SYS_MHZ;
    localparam int INIT_CYC = T_INIT_MIN_US * SYS_MHZ;
    localparam int CD2CU_CYC = (CD2CU_PERIODS * T_CCLK_MIN_NS
        + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int USER_INIT_EDGES = 8576;
    localparam int FALL_EDGES = 2;
    localparam int CLK_HALF = 3;
    localparam int IMAGE_WORDS = 16;
    localparam int WORD_W = 32;
    localparam int OPT_INIT_BIT = 0;
    localparam int OPT_UCLK_BIT = 1;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam int CTRL_START = 0;
    localparam int CTRL_WIDTH = 1;
    localparam int CTRL_MON = 3;
    localparam int CTRL_HOLD = 4;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_RST = 2'h1;
    typedef enum logic [2:0] {
        DEV_POR = 3'h0,
        DEV_ACKLOW = 3'h1,
        DEV_LOAD = 3'h3,
        DEV_START = 3'h2,
        DEV_INIT = 3'h6,
        DEV_USER = 3'h7
    } fpl_dev_state_t;
    typedef enum logic [2:0] {
        HST_IDLE = 3'h0,
        HST_REQ = 3'h1,
        HST_WAITACK = 3'h3,
        HST_SEND = 3'h2,
        HST_FINISH = 3'h6,
        HST_DONE = 3'h7
    } fpl_host_state_t;
endpackage

// ===== include/fpl_link_if.sv
`timescale 1ns/10ps
interface fpl_link_if;
    logic configRequestN;
    logic configClock;
    logic [31:0] configWord;
    logic ackDevO;
    logic ackDevOeN;
    logic ackHostO;
    logic ackHostOeN;
    logic cfgAckN;
    logic loadCompleteO;
    logic loadCompleteOeN;
    logic loadComplete;
    logic initCompleteO;
    logic initCompleteOeN;
    logic initComplete;
    // open-drain lines with pull-ups: low wins
    assign cfgAckN = !((!ackDevOeN && !ackDevO)
        || (!ackHostOeN && !ackHostO));
    assign loadComplete = !(!loadCompleteOeN && !loadCompleteO);
    assign initComplete = !(!initCompleteOeN && !initCompleteO);
    modport dev (
        input configRequestN, configClock, configWord, cfgAckN,
        output ackDevO, ackDevOeN, loadCompleteO, loadCompleteOeN,
        output initCompleteO, initCompleteOeN
    );
    modport host (
        output configRequestN, configClock, configWord,
        output ackHostO, ackHostOeN,
        input cfgAckN, loadComplete, initComplete
    );
endinterface

// ===== core/fpl_config_host.sv
`timescale 1ns/10ps
module fpl_config_host #(
    parameter int CLK_HALF = fpl_pkg::CLK_HALF,
    parameter int CF2CK_CYC = fpl_pkg::CF2CK_CYC
) (
    input wire logic sys_clk, // host clock
    input wire logic rst, // sync reset, high
    input wire logic ce, // freezes all state
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    fpl_link_if.host link // configuration pins
);
    localparam logic [31:0] CFG_END = 32'(fpl_pkg::CFG_CYC - 1);
    localparam logic [31:0] ST2CK_END = 32'(fpl_pkg::ST2CK_CYC - 1);
    localparam logic [31:0] CF2CK_END = 32'(CF2CK_CYC - 1);
    localparam logic [7:0] DIV_END = 8'(CLK_HALF - 1);
    localparam logic [1:0] FALLS = 2'(fpl_pkg::FALL_EDGES);

    fpl_pkg::fpl_host_state_t state;
    fpl_pkg::fpl_host_state_t next_state;
    logic [31:0] timer;
    logic [1:0] lcSync;
    logic [1:0] ackSync;
    logic [1:0] icSync;
    logic [1:0] widthSel;
    logic monAck;
    logic holdAck;
    logic pending;
    logic [31:0] wordQ;
    logic [7:0] divCnt;
    logic clkQ;
    logic tick;
    logic stall;
    logic [1:0] falls;
    logic access;
    logic dataWr;
    logic mapped;
    logic accept;
    logic start;

    assign access = psel && penable;
    assign mapped = paddr == fpl_pkg::REG_CTRL
        || paddr == fpl_pkg::REG_STATUS || paddr == fpl_pkg::REG_DATA;
    assign dataWr = access && pwrite && paddr == fpl_pkg::REG_DATA;
    // data writes wait here until the previous word is clocked out
    assign pready = !(dataWr && state == fpl_pkg::HST_SEND && pending);
    assign pslverr = access && (!mapped
        || (dataWr && state != fpl_pkg::HST_SEND));
    assign accept = dataWr && state == fpl_pkg::HST_SEND && !pending;
    assign start = access && pwrite && paddr == fpl_pkg::REG_CTRL
        && pwdata[fpl_pkg::CTRL_START] && state != fpl_pkg::HST_REQ;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            lcSync <= 2'h0;
            ackSync <= 2'h0;
            icSync <= 2'h0;
        end
        else if (ce)
        begin
            lcSync <= {lcSync[0], link.loadComplete};
            ackSync <= {ackSync[0], link.cfgAckN};
            icSync <= {icSync[0], link.initComplete};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            widthSel <= fpl_pkg::WIDTH_RST;
            monAck <= 1'b1;
            holdAck <= 1'b0;
            prdata <= 32'h0;
        end
        else if (ce)
        begin
            if (access && pwrite && paddr == fpl_pkg::REG_CTRL)
            begin
                widthSel <= pwdata[fpl_pkg::CTRL_WIDTH +: 2];
                monAck <= pwdata[fpl_pkg::CTRL_MON];
                holdAck <= pwdata[fpl_pkg::CTRL_HOLD];
            end
            if (psel && !penable)
            begin
                prdata <= 32'h0;
                if (paddr == fpl_pkg::REG_CTRL)
                    prdata <= {27'h0, holdAck, monAck, widthSel, 1'b0};
                else if (paddr == fpl_pkg::REG_STATUS)
                    prdata <= {24'h0, state == fpl_pkg::HST_DONE,
                        icSync[1], ackSync[1], lcSync[1], pending, state};
            end
        end
    end

    always_comb
    begin
        next_state = state;
        case (state)
            fpl_pkg::HST_IDLE, fpl_pkg::HST_DONE:
                next_state = state;
            fpl_pkg::HST_REQ:
                if (timer >= CFG_END)
                    next_state = fpl_pkg::HST_WAITACK;
            fpl_pkg::HST_WAITACK:
                if (monAck ? timer >= ST2CK_END : timer >= CF2CK_END)
                    next_state = fpl_pkg::HST_SEND;
            fpl_pkg::HST_SEND:
                if (lcSync[1] && !pending)
                    next_state = fpl_pkg::HST_FINISH;
            fpl_pkg::HST_FINISH:
                if (falls == FALLS)
                    next_state = fpl_pkg::HST_DONE;
            default:
                next_state = fpl_pkg::HST_IDLE;
        endcase
        if (start)
            next_state = fpl_pkg::HST_REQ;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= fpl_pkg::HST_IDLE;
        else if (ce)
            state <= next_state;
    end

    // with monitoring, the wait restarts while ack is still low
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            timer <= 32'h0;
        else if (ce)
        begin
            if (next_state != state || (state == fpl_pkg::HST_WAITACK
                && monAck && !ackSync[1]))
                timer <= 32'h0;
            else if (timer != 32'hffffffff)
                timer <= timer + 32'h1;
        end
    end

    // clock runs in request, finish and done; held low before a load
    // and through the wait, so the first rising edge carries word one
    assign tick = divCnt == DIV_END;
    assign stall = state == fpl_pkg::HST_IDLE
        || state == fpl_pkg::HST_WAITACK
        || (state == fpl_pkg::HST_SEND && !pending);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            divCnt <= 8'h0;
            clkQ <= 1'b0;
        end
        else if (ce)
        begin
            divCnt <= tick ? 8'h0 : divCnt + 8'h1;
            if (tick && (clkQ || !stall))
                clkQ <= !clkQ;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pending <= 1'b0;
            wordQ <= 32'h0;
        end
        else if (ce)
        begin
            if (accept)
            begin
                pending <= 1'b1;
                case (widthSel)
                    fpl_pkg::WIDTH_8: wordQ <= {24'h0, pwdata[7:0]};
                    fpl_pkg::WIDTH_16: wordQ <= {16'h0, pwdata[15:0]};
                    default: wordQ <= pwdata;
                endcase
            end
            else if (tick && !clkQ && state == fpl_pkg::HST_SEND)
                pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            falls <= 2'h0;
        else if (ce)
        begin
            if (state != fpl_pkg::HST_FINISH)
                falls <= 2'h0;
            else if (tick && clkQ && falls != FALLS)
                falls <= falls + 2'h1;
        end
    end

    assign link.configRequestN = state != fpl_pkg::HST_REQ;
    assign link.configClock = clkQ;
    assign link.configWord = wordQ;
    assign link.ackHostO = 1'b0;
    assign link.ackHostOeN = !holdAck;
endmodule // fpl_config_host

// ===== sim/fpl_link_checker.sv
`timescale 1ns/10ps
module fpl_link_checker #(
    parameter int POR_CYC = 20,
    parameter int ACK_MIN_CYC = 40,
    parameter int INIT_CYC = 30
) (
    input wire logic sys_clk, // checker clock
    input wire logic rst, // sync reset, high
    input wire logic configRequestN, // request line
    input wire logic cfgAckN, // resolved ack line
    input wire logic ackHostOeN, // host pull on ack, low = holding
    input wire logic loadComplete, // resolved complete line
    input wire logic initComplete // resolved init line
);
    int upCnt;
    int ackLowCnt;
    int cdCnt;
    logic reqSeen;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk)
        if (rst) upCnt <= 0;
        else if (upCnt < POR_CYC) upCnt <= upCnt + 1;
    always_ff @(posedge sys_clk)
        if (rst || cfgAckN) ackLowCnt <= 0;
        else ackLowCnt <= ackLowCnt + 1;
    always_ff @(posedge sys_clk)
        if (rst || !loadComplete) cdCnt <= 0;
        else cdCnt <= cdCnt + 1;
    // power-up ack low is only the reset delay, so judged apart
    always_ff @(posedge sys_clk)
        if (rst) reqSeen <= 1'b0;
        else if (!configRequestN) reqSeen <= 1'b1;
    chk_por_ack_low: assert property (upCnt < POR_CYC |-> !cfgAckN)
        else $error("ack rose inside power-on delay");
    chk_req_ack_fall: assert property
        ($fell(configRequestN) |-> ##[0:75] !cfgAckN)
        else $error("ack not low within 600 ns of request");
    chk_req_cd_fall: assert property
        ($fell(configRequestN) |-> ##[0:75] !loadComplete)
        else $error("complete not low within 600 ns of request");
    chk_ack_low_width: assert property
        (reqSeen && $rose(cfgAckN) |-> ackLowCnt >= ACK_MIN_CYC - 4)
        else $error("ack low pulse too short");
    chk_ack_release: assert property
        ($rose(configRequestN) && ackHostOeN |-> ##[0:100]
            (cfgAckN || !ackHostOeN))
        else $error("ack not released after request");
    chk_wait_no_done: assert property
        (!loadComplete && !cfgAckN |=> !loadComplete)
        else $error("complete rose while ack low");
    chk_done_stays: assert property
        (loadComplete && configRequestN |=> loadComplete)
        else $error("complete dropped without request");
    chk_init_fall: assert property
        ($fell(initComplete) |-> loadComplete && cfgAckN)
        else $error("init line fell before load complete");
    chk_init_min: assert property
        ($rose(initComplete) |-> cdCnt >= INIT_CYC)
        else $error("user mode reached too early");
endmodule // fpl_link_checker

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int WORDS = 16;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } fpl_row_t;
    logic sys_clk, rst, ce, userInitClock, psel, penable, pwrite;
    logic pready, pslverr, userMode, optInitPin, optUserClk;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic errVal;
    int fail_count, n_tests, k;
    fpl_row_t rows [4] = '{
        '{fpl_pkg::REG_CTRL, 1'b0, 32'h0, 32'h0000000a, 1'b0},
        '{fpl_pkg::REG_STATUS, 1'b0, 32'h0, 32'h00000040, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b1},
        '{fpl_pkg::REG_DATA, 1'b1, 32'h1234, 32'h0, 1'b1}};
    fpl_link_if link ();
    fpl_config_device #(.POR_CYC(20), .ACK_MIN_CYC(40), .INIT_CYC(30),
        .USER_INIT_EDGES(8), .IMAGE_WORDS(WORDS)) fpl_config_device_inst (
        .sys_clk(sys_clk), .rst(rst), .ce(ce),
        .userInitClock(userInitClock), .link(link), .userMode(userMode),
        .optInitPin(optInitPin), .optUserClk(optUserClk));
    fpl_config_host #(.CF2CK_CYC(60)) fpl_config_host_inst (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    // checker defaults match the shortened device delays above
    fpl_link_checker fpl_link_checker_inst (
        .sys_clk(sys_clk), .rst(rst),
        .configRequestN(link.configRequestN), .cfgAckN(link.cfgAckN),
        .ackHostOeN(link.ackHostOeN), .loadComplete(link.loadComplete),
        .initComplete(link.initComplete));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // slower than half the oscillator, as the device demands
    initial
    begin
        userInitClock = 1'b0;
        forever #24 userInitClock = ~userInitClock;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rdVal = prdata;
        errVal = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(logic [31:0] msk, logic [31:0] val);
        int n;
        n = 0;
        apb(fpl_pkg::REG_STATUS, 1'b0, 32'h0);
        while ((rdVal & msk) !== val && n < 3000)
        begin
            apb(fpl_pkg::REG_STATUS, 1'b0, 32'h0);
            n++;
        end
    endtask
    // one full load; mask is what the chosen width puts on the wire
    task automatic run_cfg(logic [31:0] ctrl, logic [31:0] w0,
        logic [31:0] msk);
        logic [31:0] w;
        apb(fpl_pkg::REG_CTRL, 1'b1, ctrl);
        poll(32'h7, 32'h2);
        for (int i = 0; i < WORDS; i++)
        begin
            w = (i == 0) ? w0 : 32'ha5c3_0f00 + 32'(i);
            check("loadComplete early", 32'(link.loadComplete), 0);
            apb(fpl_pkg::REG_DATA, 1'b1, w);
            check("data write err", 32'(errVal), 0);
            @(posedge link.configClock);
            check("configWord", link.configWord, w & msk);
        end
        poll(32'h80, 32'h80);
        check("loadComplete", 32'(link.loadComplete), 1);
        k = 0;
        while (userMode !== 1'b1 && k < 400)
        begin
            @(posedge sys_clk);
            k++;
        end
        check("userMode", 32'(userMode), 1);
        check("user lines", {link.configRequestN, link.cfgAckN,
            link.loadComplete}, 32'h7);
    endtask
    initial
    begin
        #400000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (40) @(posedge sys_clk);
        foreach (rows[i])
        begin
            apb(rows[i].addr, rows[i].wr, rows[i].wdata);
            if (!rows[i].wr)
                check("rdata", rdVal, rows[i].rdata);
            check("pslverr", 32'(errVal), 32'(rows[i].err));
        end
        // frozen by clock enable: a start is not taken
        ce <= 1'b0;
        apb(fpl_pkg::REG_CTRL, 1'b1, 32'h0000000b);
        ce <= 1'b1;
        @(posedge sys_clk);
        check("frozen start", 32'(link.configRequestN), 1);
        // 16-bit, ack monitored, init pin enabled
        run_cfg(32'h0000000b, 32'h1, 32'h0000ffff);
        check("optInitPin", 32'(optInitPin), 1);
        check("initComplete", 32'(link.initComplete), 1);
        apb(fpl_pkg::REG_DATA, 1'b1, 32'hffff);
        check("late data err", 32'(errVal), 1);
        check("loadComplete kept", 32'(link.loadComplete), 1);
        // 8-bit, init driven by the user clock
        run_cfg(32'h00000009, 32'h2, 32'h000000ff);
        check("optUserClk", 32'(optUserClk), 1);
        // 32-bit, ack not monitored: host waits the fixed 60-cycle delay
        run_cfg(32'h00000005, 32'h1, 32'hffffffff);
        // reset in mid-run, then a load whose ack the host holds low
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("reset lines", {link.configRequestN, link.cfgAckN,
            link.loadComplete, userMode}, 32'h8);
        apb(fpl_pkg::REG_CTRL, 1'b1, 32'h0000001b);
        poll(32'h7, 32'h3);
        repeat (300) @(posedge sys_clk);
        apb(fpl_pkg::REG_STATUS, 1'b0, 32'h0);
        check("held ack", rdVal & 32'h37, 32'h3);
        run_cfg(32'h0000000b, 32'h1, 32'h0000ffff);
        end_sim();
    end
endmodule // tb
